// [design/spsb_serial_port.sv]
// serial port core: status flags, break handling, async and sync shifters
//
// Function
// - moving a byte from buffer to shifter sets tx_buffer_empty_flag.
// - buffer writes always accepted; writing while flag is 0 overwrites unsent byte.
// - on overrun the received byte is not copied to the receive buffer.
// - framing/parity error alone still copies the byte, sets flags, full stays 0.
// - any overrun leaves full and overrun flags both 1, byte not copied.
// - a break's all-zero input sets framing error, parity error may set.
// - receiver keeps running in break; a cleared framing flag sets again.
// - with transmit disabled the output pin is a port pin of data and direction bits.
// - break sent by clearing data bit then transmit enable; pin driven low.
// - sync mode never starts transmitting while any receive error flag is 1.
// - clearing receive enable leaves the receive error flags unchanged.
// - async timing runs from a base clock at 16 times the bit rate.
// - receiver aligns to start fall, latches each bit at eighth base pulse.
// - receive error request raised while an error flag is 1 and enabled.
// - transmit empty request raised while empty flag is 1 and enabled.
// - clearing transmit enable sets empty flag and resets the shifter.
`timescale 1ns/1ns
module spsb_serial_port
  import spsb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic sck,
  input wire logic txd_in,
  output logic txd_out,
  output logic txd_oe,
  output logic rx_error_irq,
  output logic tx_empty_irq
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] pins_s;
  logic rxd_s;
  logic sck_s;
  logic pin_s;
  logic sck_prev_q;
  logic sck_rise;
  logic sck_fall;

  spsb_sync2 #(.W(3)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({txd_in, sck, rxd}),
    .sync_out(pins_s)
  );

  assign rxd_s = pins_s[0];
  assign sck_s = pins_s[1];
  assign pin_s = pins_s[2];
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;

  // ****************************************
  // apb slave and control registers
  // ****************************************
  spsb_ctrl_s ctrl_q, ctrl_d;
  logic [15:0] baud_q, baud_d;
  logic [7:0] tx_data_buffer_q, tx_data_buffer_d;
  logic [7:0] rx_data_buffer_q, rx_data_buffer_d;
  logic [DW-1:0] prdata_q, prdata_d;
  spsb_flags_s flags_q, flags_d;
  logic [NFLAGS-1:0] seen_q, seen_d;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic tx_busy;
  logic tx_load;
  spsb_rxres_s rxres;

  function automatic logic is_mapped(input logic [AW-1:0] a);
    return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_TXDATA) ||
           (a == OFS_RXDATA) || (a == OFS_BAUD);
  endfunction

  assign setup = psel & ~penable;
  assign mapped = is_mapped(paddr);
  assign wr_acc = psel & penable & pwrite & mapped;
  assign rd_acc = psel & penable & ~pwrite & mapped;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_q;

  always_comb begin
    ctrl_d = ctrl_q;
    baud_d = baud_q;
    tx_data_buffer_d = tx_data_buffer_q;
    prdata_d = prdata_q;
    if (setup && !pwrite) begin
      prdata_d = '0;
      unique case (paddr)
        OFS_CTRL: prdata_d[8:0] = ctrl_q;
        OFS_STATUS: prdata_d[7:0] = {pin_s, tx_busy, rxd_s, flags_q};
        OFS_TXDATA: prdata_d[7:0] = tx_data_buffer_q;
        OFS_RXDATA: prdata_d[7:0] = rx_data_buffer_q;
        OFS_BAUD: prdata_d[15:0] = baud_q;
        default: prdata_d = '0;
      endcase
    end
    if (wr_acc) begin
      unique case (paddr)
        OFS_CTRL: begin
          if (pstrb[0]) ctrl_d[7:0] = pwdata[7:0];
          if (pstrb[1]) ctrl_d[8] = pwdata[8];
        end
        OFS_TXDATA: begin
          if (pstrb[0]) tx_data_buffer_d = pwdata[7:0];
        end
        OFS_BAUD: begin
          if (pstrb[0]) baud_d[7:0] = pwdata[7:0];
          if (pstrb[1]) baud_d[15:8] = pwdata[15:8];
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  always_comb begin
    flags_d = flags_q;
    seen_d = seen_q;
    rx_data_buffer_d = rx_data_buffer_q;
    // a flag read as 1 arms its clear; writing 1 does nothing
    if (rd_acc && paddr == OFS_STATUS) begin
      // arm only what the setup cycle showed; a flag set since then was never seen
      seen_d = seen_q | prdata_q[NFLAGS-1:0];
    end
    if (wr_acc && paddr == OFS_STATUS && pstrb[0]) begin
      flags_d = flags_q & ~(seen_q & ~pwdata[NFLAGS-1:0]);
      seen_d = seen_q & pwdata[NFLAGS-1:0];
    end
    // hardware sets come after clears so a same-cycle set wins
    if (tx_load || !ctrl_q.transmit_enable_bit) begin
      flags_d.tx_buffer_empty_flag = 1'b1;
    end
    if (rxres.done) begin
      if (flags_q.rx_buffer_full_flag) begin
        flags_d.overrun_error_flag = 1'b1;
        flags_d.rx_buffer_full_flag = 1'b1;
      end else begin
        rx_data_buffer_d = rxres.data;
        if (rxres.frame_bad || rxres.per) begin
          flags_d.rx_buffer_full_flag = 1'b0;
        end else begin
          flags_d.rx_buffer_full_flag = 1'b1;
        end
      end
      if (rxres.frame_bad) flags_d.framing_error_flag = 1'b1;
      if (rxres.per) flags_d.per = 1'b1;
    end
  end

  // receive enable does not reach the flags, so they survive it going low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= CTRL_RST;
      baud_q <= BAUD_RST;
      tx_data_buffer_q <= '0;
      rx_data_buffer_q <= '0;
      prdata_q <= '0;
      flags_q <= FLAGS_RST;
      seen_q <= '0;
      sck_prev_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      baud_q <= baud_d;
      tx_data_buffer_q <= tx_data_buffer_d;
      rx_data_buffer_q <= rx_data_buffer_d;
      prdata_q <= prdata_d;
      flags_q <= flags_d;
      seen_q <= seen_d;
      sck_prev_q <= sck_s;
    end
  end

  assign rx_error_irq = ctrl_q.rie & (flags_q.overrun_error_flag |
                        flags_q.framing_error_flag | flags_q.per);
  assign tx_empty_irq = ctrl_q.tie & flags_q.tx_buffer_empty_flag;

  // ****************************************
  // 16x base clock
  // ****************************************
  logic [15:0] div_q, div_d;
  logic tick;

  assign tick = (div_q == baud_q);

  always_comb begin
    div_d = tick ? 16'h0000 : div_q + 16'h0001;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  spsb_tx_e tx_st_q, tx_st_d;
  logic [7:0] tx_shift_register_q, tx_shift_register_d;
  logic [3:0] tx_idx_q, tx_idx_d;
  logic [3:0] tx_sub_q, tx_sub_d;
  logic tx_line_q, tx_line_d;
  logic tx_err_block;
  logic [3:0] tx_last;

  function automatic logic odd_par(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  assign tx_err_block = ctrl_q.sync_mode & (flags_q.overrun_error_flag | flags_q.per |
                        flags_q.framing_error_flag);
  assign tx_last = ctrl_q.par_en ? 4'ha : IDX_PAR;
  assign tx_busy = (tx_st_q == TX_RUN);
  assign tx_load = ctrl_q.transmit_enable_bit & ~flags_q.tx_buffer_empty_flag & ~tx_busy &
                   ~tx_err_block;

  always_comb begin
    tx_st_d = tx_st_q;
    tx_shift_register_d = tx_shift_register_q;
    tx_idx_d = tx_idx_q;
    tx_sub_d = tx_sub_q;
    tx_line_d = tx_line_q;
    if (!ctrl_q.transmit_enable_bit) begin
      tx_st_d = TX_IDLE;
      tx_shift_register_d = '0;
      tx_idx_d = '0;
      tx_sub_d = '0;
      tx_line_d = 1'b1;
    end else begin
      unique case (tx_st_q)
        TX_IDLE: begin
          if (tx_load) begin
            tx_st_d = TX_RUN;
            tx_shift_register_d = tx_data_buffer_q;
            tx_idx_d = '0;
            tx_sub_d = '0;
          end
        end
        TX_RUN: begin
          if (ctrl_q.sync_mode) begin
            // data changes on the falling edge, line keeps the msb after
            if (sck_fall && tx_idx_q < SYNC_BITS) begin
              tx_line_d = tx_shift_register_q[tx_idx_q[2:0]];
              tx_idx_d = tx_idx_q + 4'h1;
            end else if (sck_rise && tx_idx_q == SYNC_BITS) begin
              tx_st_d = TX_IDLE;
            end
          end else begin
            if (tx_idx_q == 4'h0) begin
              tx_line_d = 1'b0;
            end else if (tx_idx_q < IDX_PAR) begin
              tx_line_d = tx_shift_register_q[tx_idx_q[2:0] - 3'h1];
            end else if (tx_idx_q == IDX_PAR && ctrl_q.par_en) begin
              tx_line_d = odd_par(tx_shift_register_q, ctrl_q.par_odd);
            end else begin
              tx_line_d = 1'b1;
            end
            if (tick) begin
              tx_sub_d = tx_sub_q + 4'h1;
              if (tx_sub_q == OVS_LAST) begin
                tx_idx_d = tx_idx_q + 4'h1;
                if (tx_idx_q == tx_last) tx_st_d = TX_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_st_q <= TX_IDLE;
      tx_shift_register_q <= '0;
      tx_idx_q <= '0;
      tx_sub_q <= '0;
      tx_line_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_shift_register_q <= tx_shift_register_d;
      tx_idx_q <= tx_idx_d;
      tx_sub_q <= tx_sub_d;
      tx_line_q <= tx_line_d;
    end
  end

  // port takeover while transmit is off lets software drive a break
  assign txd_out = ctrl_q.transmit_enable_bit ? tx_line_q : ctrl_q.port_data_bit;
  assign txd_oe = ctrl_q.transmit_enable_bit | ctrl_q.port_dir;

  // ****************************************
  // receiver
  // ****************************************
  spsb_rx_e rx_st_q, rx_st_d;
  logic [7:0] rx_shift_register_q, rx_shift_register_d;
  logic [3:0] rx_idx_q, rx_idx_d;
  logic [3:0] rx_sub_q, rx_sub_d;
  logic rx_par_q, rx_par_d;
  logic [3:0] rx_stop;
  logic rx_smp;

  assign rx_stop = ctrl_q.par_en ? 4'ha : IDX_PAR;
  assign rx_smp = tick & (rx_sub_q == OVS_SAMPLE);

  always_comb begin
    rx_st_d = rx_st_q;
    rx_shift_register_d = rx_shift_register_q;
    rx_idx_d = rx_idx_q;
    rx_sub_d = rx_sub_q;
    rx_par_d = rx_par_q;
    rxres = '0;
    rxres.data = rx_shift_register_q;
    if (!ctrl_q.receive_enable_bit) begin
      rx_st_d = RX_IDLE;
      rx_idx_d = '0;
      rx_sub_d = '0;
    end else if (ctrl_q.sync_mode) begin
      // sampled on the rising edge of the link clock
      if (sck_rise) begin
        rx_shift_register_d = {rxd_s, rx_shift_register_q[7:1]};
        rx_idx_d = rx_idx_q + 4'h1;
        if (rx_idx_q == SYNC_BITS - 4'h1) begin
          rx_idx_d = '0;
          rxres.done = 1'b1;
          rxres.data = {rxd_s, rx_shift_register_q[7:1]};
        end
      end
    end else begin
      unique case (rx_st_q)
        RX_IDLE: begin
          // level start keeps re-arming during a held break
          if (!rxd_s) begin
            rx_st_d = RX_RUN;
            rx_idx_d = '0;
            rx_sub_d = '0;
          end
        end
        RX_RUN: begin
          if (tick) rx_sub_d = rx_sub_q + 4'h1;
          if (rx_smp) begin
            rx_idx_d = rx_idx_q + 4'h1;
            if (rx_idx_q == 4'h0 && rxd_s) begin
              rx_st_d = RX_IDLE;
              // sync mode counts bits in the same index, so leave it at zero
              rx_idx_d = '0;
            end else if (rx_idx_q > 4'h0 && rx_idx_q < IDX_PAR) begin
              rx_shift_register_d = {rxd_s, rx_shift_register_q[7:1]};
            end else if (rx_idx_q == IDX_PAR && ctrl_q.par_en) begin
              rx_par_d = rxd_s;
            end else if (rx_idx_q == rx_stop) begin
              rx_st_d = RX_IDLE;
              rx_idx_d = '0;
              rxres.done = 1'b1;
              rxres.frame_bad = ~rxd_s;
              rxres.per = ctrl_q.par_en &
                          (odd_par(rx_shift_register_q, ctrl_q.par_odd) != rx_par_q);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_st_q <= RX_IDLE;
      rx_shift_register_q <= '0;
      rx_idx_q <= '0;
      rx_sub_q <= '0;
      rx_par_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_shift_register_q <= rx_shift_register_d;
      rx_idx_q <= rx_idx_d;
      rx_sub_q <= rx_sub_d;
      rx_par_q <= rx_par_d;
    end
  end

  // external clock edges are only seen two cycles late through the
  // synchroniser, hence the source must hold off after buffer reset

endmodule

// [design/spsb_pkg.sv]
// shared constants, types and register map of the serial port block
package spsb_pkg;

  localparam int unsigned DW = 32;
  localparam int unsigned AW = 8;

  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_TXDATA = 8'h08;
  localparam logic [AW-1:0] OFS_RXDATA = 8'h0c;
  localparam logic [AW-1:0] OFS_BAUD = 8'h10;

  // status field positions
  localparam int unsigned ST_TX_EMPTY = 0;
  localparam int unsigned ST_RX_FULL = 1;
  localparam int unsigned ST_OVERRUN = 2;
  localparam int unsigned ST_FRAMING = 3;
  localparam int unsigned ST_PER = 4;
  localparam int unsigned ST_RXD = 5;
  localparam int unsigned ST_TXBUSY = 6;
  localparam int unsigned ST_PIN = 7;
  localparam int unsigned NFLAGS = 5;

  // reset values
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [NFLAGS-1:0] FLAGS_RST = 5'h01;

  // timing counts
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_SAMPLE = 4'h7;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [3:0] IDX_PAR = 4'h9;

  typedef struct packed {
    logic port_dir;
    logic port_data_bit;
    logic par_odd;
    logic par_en;
    logic rie;
    logic tie;
    logic sync_mode;
    logic receive_enable_bit;
    logic transmit_enable_bit;
  } spsb_ctrl_s;

  typedef struct packed {
    logic per;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic rx_buffer_full_flag;
    logic tx_buffer_empty_flag;
  } spsb_flags_s;

  typedef struct packed {
    logic done;
    logic frame_bad;
    logic per;
    logic [7:0] data;
  } spsb_rxres_s;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_RUN = 2'b10
  } spsb_tx_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_RUN = 2'b10
  } spsb_rx_e;

endpackage

// [design/spsb_sync2.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module spsb_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // idle line level is high, so both stages come out of reset at mark
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// [tb/spsb_remote.sv]
// remote serial device model facing the tx and rx pins
`timescale 1ns/1ns
module spsb_remote (
  input wire logic clk,
  input wire logic txd_w,
  output logic rxd,
  output logic sck
);
  localparam int BIT_CLKS = 16; // one base tick a clock, 16 ticks a bit
  logic [7:0] rxq[$];
  logic [7:0] cap;
  logic in_sync = 1'b0;
  initial begin
    rxd = 1'b1;
    sck = 1'b1; // link clock stands high outside frames
  end
  // stop_ok low gives a framing fault on purpose
  task automatic send(input logic [7:0] b, input logic stop_ok);
    logic [8:0] f;
    f = {b, 1'b0};
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= stop_ok;
    repeat (10) @(posedge clk);
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
  task automatic hold_rxd(input logic v);
    @(posedge clk);
    rxd <= v;
  endtask
  // data out on each fall, tx line read at the end of the high half
  task automatic sync_xfer(input logic [7:0] tx, output logic [7:0] got);
    in_sync = 1'b1;
    #3;
    for (int i = 0; i < 8; i++) begin
      sck = 1'b0;
      rxd = tx[i];
      #40;
      sck = 1'b1;
      #37;
      got[i] = txd_w;
      #3;
    end
    rxd = 1'b1;
    // the start watcher looks 8 clocks after a fall, so stay marked past it
    #50;
    in_sync = 1'b0;
  endtask
  always begin
    @(negedge txd_w);
    repeat (BIT_CLKS / 2) @(posedge clk);
    if (txd_w === 1'b0 && !in_sync) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge clk);
        cap[i] = txd_w;
      end
      rxq.push_back(cap);
      repeat (BIT_CLKS) @(posedge clk);
    end
  end
endmodule

// [tb/spsb_serial_port_checker.sv]
// assertions on the serial port pins and register bus
`timescale 1ns/1ns
module spsb_serial_port_checker
  import spsb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic rx_error_irq,
  input wire logic tx_empty_irq
);
  logic [8:0] ctl_q;
  logic [8:0] ctl_d;
  logic acc;
  logic rd_st;
  logic mapped;
  assign acc = psel && penable;
  assign rd_st = acc && !pwrite && paddr == OFS_STATUS;
  assign mapped = paddr inside {OFS_CTRL, OFS_STATUS, OFS_TXDATA, OFS_RXDATA, OFS_BAUD};
  // shadow of the control register, rebuilt from bus writes
  always_comb begin
    ctl_d = ctl_q;
    if (acc && pwrite && paddr == OFS_CTRL) begin
      if (pstrb[0]) ctl_d[7:0] = pwdata[7:0];
      if (pstrb[1]) ctl_d[8] = pwdata[8];
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_q <= 9'h000;
    end else begin
      ctl_q <= ctl_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_no_wait;
    psel && !penable ##1 acc |-> pready;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("access without ready");
  property p_slverr;
    acc |-> pslverr == !mapped;
  endproperty
  a_slverr: assert property (p_slverr) else $error("bad error response");
  property p_port_pin;
    !ctl_q[0] |-> txd_out == ctl_q[7] && txd_oe == ctl_q[8];
  endproperty
  a_port_pin: assert property (p_port_pin) else $error("pin not port");
  property p_break;
    $fell(ctl_q[0]) && !ctl_q[7] && ctl_q[8] |-> (!txd_out && txd_oe)[*3];
  endproperty
  a_break: assert property (p_break) else $error("no break level");
  property p_tx_irq_off;
    !ctl_q[3] |-> !tx_empty_irq;
  endproperty
  a_tx_irq_off: assert property (p_tx_irq_off) else $error("tx irq masked");
  property p_te_off_irq;
    (!ctl_q[0] && ctl_q[3])[*3] |-> tx_empty_irq;
  endproperty
  a_te_off_irq: assert property (p_te_off_irq) else $error("empty not set");
  property p_rx_irq_off;
    !ctl_q[4] |-> !rx_error_irq;
  endproperty
  a_rx_irq_off: assert property (p_rx_irq_off) else $error("rx irq masked");
  property p_ovr_full;
    rd_st && prdata[2] |-> prdata[1];
  endproperty
  a_ovr_full: assert property (p_ovr_full) else $error("overrun without full");
  property p_rxd_seen;
    ($stable(rxd))[*6] ##0 rd_st |-> prdata[5] == rxd;
  endproperty
  a_rxd_seen: assert property (p_rxd_seen) else $error("rx pin level wrong");
  c_break: cover property ($fell(ctl_q[0]) && ctl_q[8]);
  c_ovr: cover property (rd_st && prdata[2]);
  c_irqs: cover property (rx_error_irq && tx_empty_irq);
endmodule
bind spsb_serial_port spsb_serial_port_checker u_chk (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
  .txd_out(txd_out), .txd_oe(txd_oe), .rx_error_irq(rx_error_irq),
  .tx_empty_irq(tx_empty_irq));

// [tb/spsb_serial_port_bench.sv]
// self-checking bench of the serial port block
`timescale 1ns/1ns
module spsb_serial_port_bench
  import spsb_pkg::*;
;
  logic clk, reset, psel, penable, pwrite, err;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, r;
  logic pready, pslverr, rxd, sck, txd_w, txd_out, txd_oe, rx_error_irq, tx_empty_irq;
  logic [7:0] b, b2, got;
  int n_mismatch, total_checks, seed, m_st;
  assign txd_w = txd_oe ? txd_out : 1'b1; // pull-up on the tx pin
  always #5 clk = ~clk;
  spsb_serial_port u_spsb_serial_port (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .sck(sck),
    .txd_in(txd_w), .txd_out(txd_out), .txd_oe(txd_oe), .rx_error_irq(rx_error_irq),
    .tx_empty_irq(tx_empty_irq));
  spsb_remote u_spsb_remote (.clk(clk), .txd_w(txd_w), .rxd(rxd), .sck(sck));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(1, 0, "bus timeout");
      tally_and_finish();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_st(input string m);
    apb(1'b0, OFS_STATUS, '0);
    chk(r[4:0], m_st[4:0], m);
  endtask
  // read arms the flags, then zeros clear what keep leaves out
  task automatic clr(input logic [4:0] keep);
    apb(1'b0, OFS_STATUS, '0);
    apb(1'b1, OFS_STATUS, {27'h0, keep});
    m_st = m_st & keep;
  endtask
  task automatic wait_tx();
    int n;
    for (n = 0; n < 400 && u_spsb_remote.rxq.size() == 0; n++) @(posedge clk);
    if (u_spsb_remote.rxq.size() == 0) begin
      chk(1, 0, "no frame");
      tally_and_finish();
    end
    got = u_spsb_remote.rxq.pop_front();
  endtask
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    seed = 96;
    m_st = 1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    chk_st("reset flags");
    apb(1'b0, 8'h20, '0);
    chk(err, 1, "unmapped err");
    chk(r, 0, "unmapped data");
    apb(1'b1, OFS_CTRL, 32'h100);
    #1;
    chk(txd_w, 0, "port pin low");
    apb(1'b1, OFS_CTRL, 32'h180);
    #1;
    chk(txd_w, 1, "port pin mark");
    u_spsb_remote.rxq.delete();
    // transmit on first: while it is off the empty flag is held set
    apb(1'b1, OFS_CTRL, 32'h19b);
    b = 8'($random(seed));
    b2 = 8'($random(seed));
    apb(1'b1, OFS_TXDATA, {24'h0, b});
    clr(5'h1e);
    m_st = 1;
    chk_st("empty after first load");
    apb(1'b1, OFS_TXDATA, {24'h0, b2});
    clr(5'h1e);
    b2 = 8'($random(seed));
    apb(1'b1, OFS_TXDATA, {24'h0, b2});
    wait_tx();
    chk(got, b, "first byte sent");
    wait_tx();
    chk(got, b2, "overwritten byte sent");
    m_st = 1;
    chk_st("empty after load");
    chk(tx_empty_irq, 1, "tx irq");
    b = 8'($random(seed));
    u_spsb_remote.send(b, 1'b1);
    m_st = m_st | 2;
    chk_st("rx full");
    apb(1'b0, OFS_RXDATA, '0);
    chk(r, {24'h0, b}, "rx byte");
    b2 = 8'($random(seed));
    u_spsb_remote.send(b2, 1'b1);
    m_st = m_st | 4;
    chk_st("overrun flags");
    apb(1'b0, OFS_RXDATA, '0);
    chk(r, {24'h0, b}, "overrun keeps byte");
    chk(rx_error_irq, 1, "err irq");
    apb(1'b1, OFS_STATUS, 32'h1f);
    chk_st("ones ignored");
    clr(5'h01);
    chk_st("flags cleared");
    b = 8'($random(seed));
    u_spsb_remote.send(b, 1'b0);
    m_st = m_st | 8;
    chk_st("framing only");
    apb(1'b0, OFS_RXDATA, '0);
    chk(r, {24'h0, b}, "framing byte kept");
    apb(1'b1, OFS_CTRL, 32'h199);
    chk_st("rx off keeps flags");
    apb(1'b1, OFS_CTRL, 32'h19b);
    u_spsb_remote.hold_rxd(1'b0);
    repeat (300) @(posedge clk);
    clr(5'h17);
    repeat (300) @(posedge clk);
    apb(1'b0, OFS_STATUS, '0);
    chk(r[3], 1, "break framing again");
    chk(r[5], 0, "break pin low");
    u_spsb_remote.hold_rxd(1'b1);
    repeat (300) @(posedge clk);
    apb(1'b1, OFS_CTRL, 32'h19f);
    b = 8'($random(seed));
    apb(1'b1, OFS_TXDATA, {24'h0, b});
    clr(5'h1e);
    repeat (30) @(posedge clk);
    apb(1'b0, OFS_STATUS, '0);
    chk(r[0], 0, "sync blocked");
    clr(5'h00);
    repeat (10) @(posedge clk);
    m_st = 1;
    chk_st("sync loads");
    b2 = 8'($random(seed));
    u_spsb_remote.sync_xfer(b2, got);
    chk(got, b, "sync tx byte");
    repeat (10) @(posedge clk);
    m_st = 3;
    chk_st("sync rx full");
    apb(1'b0, OFS_RXDATA, '0);
    chk(r, {24'h0, b2}, "sync rx byte");
    apb(1'b1, OFS_CTRL, 32'h19b);
    apb(1'b1, OFS_TXDATA, {24'h0, b});
    clr(5'h1e);
    repeat (40) @(posedge clk);
    apb(1'b1, OFS_CTRL, 32'h11b);
    apb(1'b1, OFS_CTRL, 32'h11a);
    #1;
    chk(txd_w, 0, "break sent");
    m_st = 3;
    chk_st("empty on disable");
    repeat (5) @(posedge clk);
    tally_and_finish();
  end
endmodule
